/* pllsel_host_model.sv */
// Purpose: behavioural host that writes and reads the configuration registers
// Assumes: requests launched just after a rising edge, one strobe cycle each
// Notes:   writes that the host may never issue are dropped before the bus
`timescale 1ns/1ps
module pllsel_host_model
    import pllsel_pkg::*;
#(
    parameter bit BYPASS_MODE = 1'b0,
    parameter bit LOW_SUPPLY  = 1'b0
) (
    // clock
    input  wire logic       clk_sys_in,
    // register port
    output pllsel_req_t     reg_req_out,
    input  wire logic [7:0] reg_rdata_in,
    input  wire logic       reg_rvalid_in
);
    // idle bus until the first request
    initial reg_req_out = '0;

    // host side limits, checked before anything reaches the device
    function automatic bit host_may_write(input logic [7:0] a, input logic [7:0] d);
        bit ok;
        ok = 1'b1;
        if (a === ADDR_CMOS_DRIVE && d[7:6] === 2'b11) ok = 1'b0;
        if (a === ADDR_OUT_FMT && BYPASS_MODE && (d[2:0] === FMT_CMOS || d[5:3] === FMT_CMOS)) ok = 1'b0;
        if (a === ADDR_OUT_FMT && LOW_SUPPLY && (d[2:0] === FMT_LVPECL || d[5:3] === FMT_LVPECL)) ok = 1'b0;
        return ok;
    endfunction

    // one write strobe, released at the edge that takes it
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        if (host_may_write(a, d)) begin
            @(posedge clk_sys_in);
            reg_req_out <= '{1'b1, 1'b0, a, d};
            @(posedge clk_sys_in);
            reg_req_out <= '0;
        end
    endtask

    // one read strobe, data taken in the cycle that valid stands
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        d = 'x;
        @(posedge clk_sys_in);
        reg_req_out <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys_in);
        reg_req_out <= '0;
        for (n = 0; n < 4; n++) begin
            #1;
            if (reg_rvalid_in === 1'b1) begin
                d = reg_rdata_in;
                break;
            end
            @(posedge clk_sys_in);
        end
    endtask
endmodule

/* pllsel_pkg.sv */
// Purpose: shared constants and types for the input select / output format register slice
// Assumes: byte-wide register port, 8-bit register addresses
// Notes:   register bytes are stored whole; write masks keep reserved bits at reset value
package pllsel_pkg;

    // register addresses
    localparam logic [7:0] ADDR_ISEL_HOLD  = 8'h03;
    localparam logic [7:0] ADDR_METH_HIST  = 8'h04;
    localparam logic [7:0] ADDR_CMOS_DRIVE = 8'h05;
    localparam logic [7:0] ADDR_OUT_FMT    = 8'h06;
    localparam logic [7:0] ADDR_BASE       = 8'h03;
    localparam int         NUM_REGS        = 4;

    // register indices inside the local array
    localparam int IDX_ISEL = 0;
    localparam int IDX_METH = 1;
    localparam int IDX_CMOS = 2;
    localparam int IDX_FMT  = 3;

    // reset values, index 0 is the lowest address
    localparam logic [NUM_REGS-1:0][7:0] REG_RST  = {8'h2D, 8'hED, 8'h12, 8'h05};
    // writable bits; every other bit is reserved and read only
    localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {8'h3F, 8'hC0, 8'hDF, 8'hF0};

    // field positions
    localparam int MAN_CHOICE_MSB = 7;
    localparam int MAN_CHOICE_LSB = 6;
    localparam int HOLD_BIT       = 5;
    localparam int SQUELCH_BIT    = 4;
    localparam int METHOD_MSB     = 7;
    localparam int METHOD_LSB     = 6;
    localparam int HIST_MSB       = 4;
    localparam int HIST_LSB       = 0;
    localparam int DRIVE_MSB      = 7;
    localparam int DRIVE_LSB      = 6;
    localparam int FMT_WIDTH      = 3;
    localparam int NUM_OUTS       = 2;

    // reserved low nibble of the select register
    localparam logic [3:0] ISEL_RSVD_VAL = 4'h5;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // selection method codes
    typedef enum logic [1:0] {
        PLLSEL_MANUAL    = 2'b00,
        PLLSEL_AUTO_NREV = 2'b01,
        PLLSEL_AUTO_REV  = 2'b10,
        PLLSEL_RSVD      = 2'b11
    } pllsel_method_t;

    // manual input choice codes
    localparam logic [1:0] CHOICE_ONE = 2'b00;
    localparam logic [1:0] CHOICE_TWO = 2'b01;

    // output format codes
    localparam logic [2:0] FMT_RSVD0   = 3'h0;
    localparam logic [2:0] FMT_DISABLE = 3'h1;
    localparam logic [2:0] FMT_CMOS    = 3'h2;
    localparam logic [2:0] FMT_LSLVDS  = 3'h3;
    localparam logic [2:0] FMT_RSVD4   = 3'h4;
    localparam logic [2:0] FMT_LVPECL  = 3'h5;
    localparam logic [2:0] FMT_CML     = 3'h6;
    localparam logic [2:0] FMT_LVDS    = 3'h7;

    // register access request from the serial host engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pllsel_req_t;

endpackage

/* pllsel_regs.sv */
// Purpose: input selection, holdover and output format configuration registers
// Assumes: register port driven by the serial host engine on the system clock
// Notes:   select pin is asynchronous; all other inputs come from same-clock logic
`timescale 1ns/1ps
// Function
// (RULE1) manual register choice picks active input
// (RULE2) pin-select enable hands choice to pin
// (RULE3) force holdover overrides all selection
// (RULE4) squelch bit mutes outputs during calibration
// (RULE5) method field: manual, non-revertive, revertive
// (RULE6) history delay field drives holdover history
// (RULE7) output two format field selects buffer
// (RULE8) output one format field, same encoding
// (RULE9) host avoids CMOS format in bypass
// (RULE10) host avoids LVPECL on low supply
// (RULE11) drive strength code 11 unused by host
// (RULE12) reset values 0x05 and 0x12 readable
// (RULE13) never-muted bypasses calibration squelch
// (RULE14) automatic methods ignore manual choice, pin
// (RULE15) reserved bits read-only, keep reset value
module pllsel_regs
    import pllsel_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    // register access port
    input  wire pllsel_req_t reg_req_in,
    output logic [7:0]       reg_rdata_out,
    output logic             reg_rvalid_out,
    // selection inputs
    input  wire logic        ext_select_pin_in,
    input  wire logic        pin_select_enable_in,
    input  wire logic        auto_choice_in,
    // calibration status
    input  wire logic        cal_active_in,
    input  wire logic        output_never_muted_in,
    // selection results
    output logic             active_input_out,
    output logic             holdover_out,
    output logic             auto_mode_out,
    output logic             revertive_out,
    output logic [4:0]       history_delay_out,
    // output buffer controls
    output logic [1:0]       cmos_drive_strength_out,
    output logic [2:0]       out_one_format_out,
    output logic [2:0]       out_two_format_out,
    output logic             out_one_enable_out,
    output logic             out_two_enable_out
);

    // register storage and decoded fields
    logic [NUM_REGS-1:0][7:0] reg_ff;
    logic [1:0]               manual_input_choice;
    logic                     force_holdover;
    logic                     squelch_during_cal;
    pllsel_method_t           selection_method;
    logic [NUM_OUTS-1:0][2:0] out_format;
    logic [NUM_OUTS-1:0]      out_en_ff;
    logic                     pin_level;
    logic                     nxt_active;
    logic                     active_ff;
    logic                     squelch_now;
    logic [7:0]               nxt_rdata;

    // external select pin crosses in from outside the clock domain
    pllsel_sync3 u_pin_sync (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .async_in   (ext_select_pin_in),
        .level_out  (pin_level)
    );

    // field decode straight from the stored bytes
    assign manual_input_choice = reg_ff[IDX_ISEL][MAN_CHOICE_MSB:MAN_CHOICE_LSB];
    assign force_holdover      = reg_ff[IDX_ISEL][HOLD_BIT];
    assign squelch_during_cal  = reg_ff[IDX_ISEL][SQUELCH_BIT];
    assign selection_method    = pllsel_method_t'(reg_ff[IDX_METH][METHOD_MSB:METHOD_LSB]);
    assign out_format[0]       = reg_ff[IDX_FMT][FMT_WIDTH-1:0];
    assign out_format[1]       = reg_ff[IDX_FMT][2*FMT_WIDTH-1:FMT_WIDTH];

    // register bytes; masked merge keeps reserved bits at their reset value
    // codes the host must avoid (CMOS in bypass, LVPECL on low supply, drive 11)
    // are stored as written, policing them is left to the host
    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
            // (RULE12) reset values loaded
            // (RULE15) reserved bits masked
            always_ff @(posedge clk_sys_in) begin
                if (srst_in) begin
                    reg_ff[g] <= REG_RST[g];
                end else if (reg_req_in.wr && (reg_req_in.addr == ADDR_BASE + 8'(g))) begin
                    reg_ff[g] <= (reg_req_in.wdata & REG_MASK[g]) | (REG_RST[g] & ~REG_MASK[g]);
                end
            end
        end
    endgenerate

    // read mux; unmapped addresses answer with zero
    always_comb begin
        nxt_rdata = UNMAPPED_DATA;
        case (reg_req_in.addr)
            ADDR_ISEL_HOLD:  nxt_rdata = reg_ff[IDX_ISEL];
            ADDR_METH_HIST:  nxt_rdata = reg_ff[IDX_METH];
            ADDR_CMOS_DRIVE: nxt_rdata = reg_ff[IDX_CMOS];
            ADDR_OUT_FMT:    nxt_rdata = reg_ff[IDX_FMT];
            default:         nxt_rdata = UNMAPPED_DATA;
        endcase
    end

    // read data lands one cycle after the strobe and holds until the next read
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            reg_rdata_out  <= UNMAPPED_DATA;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_req_in.rd;
            if (reg_req_in.rd) begin
                reg_rdata_out <= nxt_rdata;
            end
        end
    end

    // active input selection; reserved codes keep the previous choice
    // so a bad write never glitches the reference over to the other input
    always_comb begin
        nxt_active = active_ff;
        // (RULE3) holdover freezes selection
        if (force_holdover) begin
            nxt_active = active_ff;
        end else begin
            // (RULE5) method field decode
            case (selection_method)
                PLLSEL_MANUAL: begin
                    // (RULE2) pin overrides register
                    if (pin_select_enable_in) begin
                        nxt_active = pin_level;
                    // (RULE1) register manual choice
                    end else if (manual_input_choice == CHOICE_ONE) begin
                        nxt_active = 1'b0;
                    end else if (manual_input_choice == CHOICE_TWO) begin
                        nxt_active = 1'b1;
                    end
                end
                // (RULE14) automatic ignores manual controls
                PLLSEL_AUTO_NREV: nxt_active = auto_choice_in;
                PLLSEL_AUTO_REV:  nxt_active = auto_choice_in;
                default:          nxt_active = active_ff;
            endcase
        end
    end

    // selection state
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= nxt_active;
        end
    end

    assign active_input_out = active_ff;

    // mode flags for the holdover and autoselect engines
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            holdover_out  <= 1'b0;
            auto_mode_out <= 1'b0;
            revertive_out <= 1'b0;
        end else begin
            // (RULE3) holdover flag driven
            holdover_out  <= force_holdover;
            // (RULE5) automatic mode flags
            auto_mode_out <= (selection_method == PLLSEL_AUTO_NREV) || (selection_method == PLLSEL_AUTO_REV);
            revertive_out <= (selection_method == PLLSEL_AUTO_REV);
        end
    end

    // configuration fields handed on to the datapath
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            history_delay_out       <= REG_RST[IDX_METH][HIST_MSB:HIST_LSB];
            cmos_drive_strength_out <= REG_RST[IDX_CMOS][DRIVE_MSB:DRIVE_LSB];
            out_one_format_out      <= REG_RST[IDX_FMT][FMT_WIDTH-1:0];
            out_two_format_out      <= REG_RST[IDX_FMT][2*FMT_WIDTH-1:FMT_WIDTH];
        end else begin
            // (RULE6) history delay forwarded
            history_delay_out       <= reg_ff[IDX_METH][HIST_MSB:HIST_LSB];
            cmos_drive_strength_out <= reg_ff[IDX_CMOS][DRIVE_MSB:DRIVE_LSB];
            out_one_format_out      <= out_format[0];
            out_two_format_out      <= out_format[1];
        end
    end

    // (RULE4) squelch during calibration
    // (RULE13) never-muted overrides squelch
    assign squelch_now = squelch_during_cal && cal_active_in && !output_never_muted_in;

    // per-output buffer enable; reserved format codes keep the buffer off
    generate
        for (genvar o = 0; o < NUM_OUTS; o++) begin : g_out
            // (RULE7) format decode per output
            // (RULE8) same decode for output one
            always_ff @(posedge clk_sys_in) begin
                if (srst_in) begin
                    out_en_ff[o] <= 1'b0;
                end else begin
                    out_en_ff[o] <= !squelch_now
                                 && (out_format[o] != FMT_DISABLE)
                                 && (out_format[o] != FMT_RSVD0)
                                 && (out_format[o] != FMT_RSVD4);
                end
            end
        end
    endgenerate

    assign out_one_enable_out = out_en_ff[0];
    assign out_two_enable_out = out_en_ff[1];

    // checks kept beside the logic they guard

    a_reset_regs_value: assert property ( // (RULE12)
        @(posedge clk_sys_in) $past(srst_in) && !srst_in |->
            reg_ff[IDX_ISEL] == 8'h05 && reg_ff[IDX_METH] == 8'h12)
        else $error("register reset values wrong");

    a_reserved_bits_hold: assert property ( // (RULE15)
        @(posedge clk_sys_in) disable iff (srst_in)
        reg_req_in.rd && reg_req_in.addr == ADDR_ISEL_HOLD |=> reg_rdata_out[3:0] == ISEL_RSVD_VAL)
        else $error("reserved bits changed");

    a_manual_reg_pick: assert property ( // (RULE1)
        @(posedge clk_sys_in) disable iff (srst_in)
        !force_holdover && selection_method == PLLSEL_MANUAL && !pin_select_enable_in
            && manual_input_choice == CHOICE_TWO |=> active_input_out)
        else $error("manual choice two not taken");

    a_manual_one_pick: assert property ( // (RULE1)
        @(posedge clk_sys_in) disable iff (srst_in)
        !force_holdover && selection_method == PLLSEL_MANUAL && !pin_select_enable_in
            && manual_input_choice == CHOICE_ONE |=> !active_input_out)
        else $error("manual choice one not taken");

    a_pin_select_pick: assert property ( // (RULE2)
        @(posedge clk_sys_in) disable iff (srst_in)
        !force_holdover && selection_method == PLLSEL_MANUAL && pin_select_enable_in
            |=> active_input_out == $past(pin_level))
        else $error("select pin not followed");

    a_holdover_freeze: assert property ( // (RULE3)
        @(posedge clk_sys_in) disable iff (srst_in)
        force_holdover |=> $stable(active_input_out) ##0 holdover_out)
        else $error("selection moved during holdover");

    a_auto_follow: assert property ( // (RULE14)
        @(posedge clk_sys_in) disable iff (srst_in)
        !force_holdover && (selection_method == PLLSEL_AUTO_NREV || selection_method == PLLSEL_AUTO_REV)
            |=> active_input_out == $past(auto_choice_in) && auto_mode_out)
        else $error("automatic choice not followed");

    a_squelch_mutes: assert property ( // (RULE4)
        @(posedge clk_sys_in) disable iff (srst_in)
        squelch_during_cal && cal_active_in && !output_never_muted_in
            |=> !out_one_enable_out && !out_two_enable_out)
        else $error("outputs not squelched in calibration");

    a_never_muted_on: assert property ( // (RULE13)
        @(posedge clk_sys_in) disable iff (srst_in)
        output_never_muted_in && out_format[0] == FMT_LVDS |=> out_one_enable_out)
        else $error("never-muted output was squelched");

    a_disable_two_off: assert property ( // (RULE7)
        @(posedge clk_sys_in) disable iff (srst_in)
        out_format[1] == FMT_DISABLE |=> !out_two_enable_out && out_two_format_out == FMT_DISABLE)
        else $error("output two not disabled");

    a_disable_one_off: assert property ( // (RULE8)
        @(posedge clk_sys_in) disable iff (srst_in)
        out_format[0] == FMT_DISABLE |=> !out_one_enable_out)
        else $error("output one not disabled");

    a_hist_write_lands: assert property ( // (RULE6)
        @(posedge clk_sys_in) disable iff (srst_in)
        reg_req_in.wr && reg_req_in.addr == ADDR_METH_HIST
            |=> ##1 history_delay_out == $past(reg_req_in.wdata[4:0], 2))
        else $error("history delay write lost");

    a_method_revert: assert property ( // (RULE5)
        @(posedge clk_sys_in) disable iff (srst_in)
        selection_method == PLLSEL_AUTO_REV |=> revertive_out && auto_mode_out)
        else $error("revertive mode flag wrong");

    a_format_forward: assert property ( // (RULE7)
        @(posedge clk_sys_in) disable iff (srst_in)
        1'b1 |=> out_one_format_out == $past(out_format[0]) && out_two_format_out == $past(out_format[1]))
        else $error("format fields not forwarded");

    a_hold_flag_clear: assert property ( // (RULE3)
        @(posedge clk_sys_in) disable iff (srst_in)
        !force_holdover |=> !holdover_out)
        else $error("holdover flag set without request");

    a_unsquelched_out_on: assert property ( // (RULE4)
        @(posedge clk_sys_in) disable iff (srst_in)
        !squelch_during_cal && out_format[1] == FMT_LVDS |=> out_two_enable_out)
        else $error("output muted with squelch off");

endmodule

/* pllsel_sync3.sv */
// Purpose: three-stage synchroniser for an asynchronous level input
// Assumes: single clock, synchronous active-high reset
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module pllsel_sync3 (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic srst_in,
    // async level in, filtered level out
    input  wire logic async_in,
    output logic      level_out
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    // shift chain; first stage feeds only the second
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // accept a change only once two late stages agree, rejects one-cycle glitches
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            level_out <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            level_out <= s3_ff;
        end
    end

endmodule

/* testbench.sv */
// Purpose: self-checking bench for the select, holdover and format registers
// Assumes: host model drives the register port, bench drives the side inputs
// Notes:   pin path waits ten cycles to cover the synchroniser
`timescale 1ns/1ps
module testbench
    import pllsel_pkg::*;
();
    logic        clk_sys_in = 1'b0;
    logic        srst_in    = 1'b1;
    pllsel_req_t reg_req;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        pin_en = 1'b0, ext_pin = 1'b0, auto_choice = 1'b0, cal = 1'b0, never_muted = 1'b0;
    logic        active, holdover, auto_mode, revertive, en1, en2;
    logic [4:0]  hist;
    logic [1:0]  drive;
    logic [2:0]  fmt1, fmt2;
    int          bad_count = 0;
    int          checked   = 0;

    // free-running system clock
    always #5 clk_sys_in = ~clk_sys_in;

    pllsel_host_model i_host (.clk_sys_in(clk_sys_in), .reg_req_out(reg_req), .reg_rdata_in(rdata),
                              .reg_rvalid_in(rvalid));

    pllsel_regs i_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_req_in(reg_req),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .ext_select_pin_in(ext_pin),
        .pin_select_enable_in(pin_en), .auto_choice_in(auto_choice), .cal_active_in(cal),
        .output_never_muted_in(never_muted), .active_input_out(active), .holdover_out(holdover),
        .auto_mode_out(auto_mode), .revertive_out(revertive), .history_delay_out(hist),
        .cmos_drive_strength_out(drive), .out_one_format_out(fmt1), .out_two_format_out(fmt2),
        .out_one_enable_out(en1), .out_two_enable_out(en2));

    // compare and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.read_reg(a, d);
        chk(name, d, exp);
    endtask

    // let derived outputs land, then sample clear of the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    // side inputs change together just after an edge
    task automatic set_in(input logic pe, input logic ep, input logic ac, input logic ca, input logic nm);
        @(posedge clk_sys_in);
        pin_en      <= pe;
        ext_pin     <= ep;
        auto_choice <= ac;
        cal         <= ca;
        never_muted <= nm;
    endtask

    // reserved and disable codes leave the buffer off
    function automatic logic en_exp(input logic [2:0] f);
        return !(f inside {FMT_RSVD0, FMT_DISABLE, FMT_RSVD4});
    endfunction

    task automatic t_reset_values();
        rd_chk("isel", ADDR_ISEL_HOLD, 8'h05);
        rd_chk("meth", ADDR_METH_HIST, 8'h12);
        rd_chk("cmos", ADDR_CMOS_DRIVE, 8'hED);
        rd_chk("fmt", ADDR_OUT_FMT, 8'h2D);
        chk("hist", {3'h0, hist}, 8'h12);
        chk("en", {6'h0, en2, en1}, 8'h03);
        $display("test reset_values done");
    endtask

    task automatic t_reserved();
        i_host.write_reg(ADDR_ISEL_HOLD, 8'hFF);
        i_host.write_reg(ADDR_METH_HIST, 8'hFF);
        i_host.write_reg(ADDR_CMOS_DRIVE, 8'hBF);
        i_host.write_reg(ADDR_OUT_FMT, 8'hFF);
        i_host.write_reg(8'h07, 8'hFF);
        rd_chk("isel", ADDR_ISEL_HOLD, 8'hF5);
        rd_chk("meth", ADDR_METH_HIST, 8'hDF);
        rd_chk("cmos", ADDR_CMOS_DRIVE, 8'hAD);
        rd_chk("fmt", ADDR_OUT_FMT, 8'h3F);
        rd_chk("unmapped", 8'h07, 8'h00);
        for (int a = 3; a < 7; a++) i_host.write_reg(8'(a), 8'h00);
        rd_chk("isel", ADDR_ISEL_HOLD, 8'h05);
        rd_chk("cmos", ADDR_CMOS_DRIVE, 8'h2D);
        $display("test reserved done");
    endtask

    task automatic t_manual();
        i_host.write_reg(ADDR_ISEL_HOLD, 8'h40);
        settle(3);
        chk("active", {7'h0, active}, 8'h01);
        set_in(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        settle(10);
        chk("active", {7'h0, active}, 8'h00);
        set_in(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        i_host.write_reg(ADDR_ISEL_HOLD, 8'h00);
        settle(10);
        chk("active", {7'h0, active}, 8'h01);
        set_in(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        settle(3);
        chk("active", {7'h0, active}, 8'h00);
        $display("test manual done");
    endtask

    task automatic t_auto();
        for (int m = 1; m < 3; m++) begin
            i_host.write_reg(ADDR_ISEL_HOLD, 8'h00);
            i_host.write_reg(ADDR_METH_HIST, {2'(m), 6'h0A});
            set_in(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
            settle(10);
            chk("active", {7'h0, active}, 8'h01);
            chk("mode", {6'h0, auto_mode, revertive}, {6'h0, 1'b1, m == 2});
            chk("hist", {3'h0, hist}, 8'h0A);
            i_host.write_reg(ADDR_ISEL_HOLD, 8'h40);
            set_in(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
            settle(10);
            chk("active", {7'h0, active}, 8'h00);
        end
        i_host.write_reg(ADDR_METH_HIST, 8'h00);
        set_in(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        settle(3);
        chk("mode", {6'h0, auto_mode, revertive}, 8'h00);
        $display("test auto done");
    endtask

    task automatic t_hold();
        i_host.write_reg(ADDR_ISEL_HOLD, 8'h20);
        i_host.write_reg(ADDR_METH_HIST, 8'h40);
        set_in(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        settle(6);
        chk("hold", {6'h0, holdover, active}, 8'h03);
        i_host.write_reg(ADDR_ISEL_HOLD, 8'h00);
        settle(3);
        chk("hold", {6'h0, holdover, active}, 8'h00);
        i_host.write_reg(ADDR_METH_HIST, 8'h00);
        $display("test hold done");
    endtask

    task automatic t_formats();
        for (int c = 0; c < 8; c++) begin
            i_host.write_reg(ADDR_OUT_FMT, {2'b00, ~3'(c), 3'(c)});
            settle(3);
            chk("fmt", {2'h0, fmt2, fmt1}, {2'h0, ~3'(c), 3'(c)});
            chk("en", {6'h0, en2, en1}, {6'h0, en_exp(~3'(c)), en_exp(3'(c))});
        end
        for (int d = 0; d < 3; d++) begin
            i_host.write_reg(ADDR_CMOS_DRIVE, {2'(d), 6'h00});
            settle(3);
            chk("drive", {6'h0, drive}, 8'(d));
        end
        // drive code 11 is withheld by the host, so the last legal code stays
        i_host.write_reg(ADDR_CMOS_DRIVE, 8'hC0);
        settle(3);
        chk("drive", {6'h0, drive}, 8'h02);
        $display("test formats done");
    endtask

    task automatic t_squelch();
        i_host.write_reg(ADDR_OUT_FMT, 8'h3F);
        i_host.write_reg(ADDR_ISEL_HOLD, 8'h10);
        set_in(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        settle(3);
        chk("en", {6'h0, en2, en1}, 8'h00);
        set_in(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        settle(3);
        chk("en", {6'h0, en2, en1}, 8'h03);
        set_in(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        settle(3);
        chk("en", {6'h0, en2, en1}, 8'h03);
        i_host.write_reg(ADDR_ISEL_HOLD, 8'h00);
        set_in(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        settle(3);
        chk("en", {6'h0, en2, en1}, 8'h03);
        $display("test squelch done");
    endtask

    // counts, verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        settle(2);
        t_reset_values();
        t_reserved();
        t_manual();
        t_auto();
        t_hold();
        t_formats();
        t_squelch();
        wrap_up();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        bad_count++;
        wrap_up();
    end
endmodule
